// file: rtl/bltf_pkg.sv
// Package with register map, field layout and timing for backlight control
package bltf_pkg;
   // Register offsets
   localparam logic [7:0] BLTF_OFS_SINK_SEL = 8'h05;
   localparam logic [7:0] BLTF_OFS_OFF_TMO  = 8'h06;
   localparam logic [7:0] BLTF_OFS_DIM_TMO  = 8'h07;
   localparam logic [7:0] BLTF_OFS_FADE     = 8'h08;
   // Reset values of the registers
   localparam logic [6:0] BLTF_RST_SINK_SEL = 7'h00;
   localparam logic [6:0] BLTF_RST_OFF_TMO  = 7'h00;
   localparam logic [6:0] BLTF_RST_DIM_TMO  = 7'h00;
   localparam logic [7:0] BLTF_RST_FADE     = 8'h00;
   // Field positions
   localparam int BLTF_NUM_LEDS   = 7;
   localparam int BLTF_TMO_MSB    = 6;
   localparam int BLTF_FO_MSB     = 7;
   localparam int BLTF_FO_LSB     = 4;
   localparam int BLTF_FI_MSB     = 3;
   localparam int BLTF_FI_LSB     = 0;
   // Transfer law codes
   localparam logic [1:0] BLTF_LAW_LIN    = 2'h0;
   localparam logic [1:0] BLTF_LAW_SQR    = 2'h1;
   localparam logic [1:0] BLTF_LAW_CUB10  = 2'h2;
   localparam logic [1:0] BLTF_LAW_CUB11  = 2'h3;
   // Timing: full-scale fade is 127 DAC steps, one second is 1000 ms
   localparam int BLTF_FULL_STEPS = 127;
   localparam int BLTF_SEC_MS     = 1000;
   localparam int BLTF_CLK_KHZ    = 25000;
   // Low band of the current code where cubic laws slow the ramp
   localparam logic [6:0] BLTF_CUB_LOW_HALF = 7'h40;
   localparam logic [6:0] BLTF_CUB_LOW_QTR  = 7'h20;

   // Full-scale fade time in ms for a 4-bit rate code
   function automatic int bltf_fade_ms(input logic [3:0] code);
      case (code)
         4'h0: bltf_fade_ms = 100;
         4'hb: bltf_fade_ms = 3500;
         4'hc: bltf_fade_ms = 4000;
         4'hd: bltf_fade_ms = 4000;
         4'he: bltf_fade_ms = 4500;
         4'hf: bltf_fade_ms = 5500;
         default: bltf_fade_ms = 300 * int'(code);
      endcase
   endfunction

   // Clock cycles per DAC step, rounded down, never below one
   function automatic logic [31:0] bltf_step_cyc(input logic [3:0] code,
                                                 input int clk_khz);
      longint cyc;
      cyc = (longint'(bltf_fade_ms(code)) * longint'(clk_khz))
            / longint'(BLTF_FULL_STEPS);
      if (cyc < 1) begin
         cyc = 1;
      end
      bltf_step_cyc = cyc[31:0];
   endfunction
endpackage

// file: rtl/bltf_ramp_if.sv
// Interface between backlight sequencer and the fade ramp engine
`timescale 1ns/100ps
`default_nettype none
interface bltf_ramp_if;
   logic [6:0]  target;    // Code the ramp heads for
   logic [31:0] step_cyc;  // Cycles per code step
   logic [1:0]  law;       // Transfer law
   logic [6:0]  level;     // Present ramp code
   logic        done;      // Level equals target

   modport ctl (output target, output step_cyc, output law,
                input level, input done);
   modport eng (input target, input step_cyc, input law,
                output level, output done);
endinterface
`default_nettype wire

// file: rtl/bltf_ramp.sv
// Fade ramp engine stepping the backlight code toward its target
`timescale 1ns/100ps
`default_nettype none
module bltf_ramp
   import bltf_pkg::*;
(
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic rstn_i,
   input  wire logic ce_i,
   // Sequencer side
   bltf_ramp_if.eng  rmp
);
   typedef struct packed {
      logic [6:0]  level;
      logic [31:0] cnt;
   } bltf_ramp_st_t;

   bltf_ramp_st_t r;
   bltf_ramp_st_t n;
   logic [31:0]   eff_cyc;

   // Step timing and one-code moves toward the target
   always_comb begin
      n = r;
      eff_cyc = rmp.step_cyc;
      if (rmp.law == BLTF_LAW_CUB10 && r.level < BLTF_CUB_LOW_HALF) begin
         eff_cyc = {rmp.step_cyc[30:0], 1'b0};
      end else if (rmp.law == BLTF_LAW_CUB11 &&
                   r.level < BLTF_CUB_LOW_QTR) begin
         eff_cyc = {rmp.step_cyc[29:0], 2'b00};
      end
      if (r.level == rmp.target) begin
         n.cnt = 32'h0000_0000;
      end else if (r.cnt + 32'h0000_0001 >= eff_cyc) begin
         n.cnt = 32'h0000_0000;
         // Step time does not depend on move length, so a shorter move ends sooner
         if (r.level < rmp.target) begin
            n.level = r.level + 7'h01;
         end else begin
            n.level = r.level - 7'h01;
         end
      end else begin
         n.cnt = r.cnt + 32'h0000_0001;
      end
   end

   // State register
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r <= '0;
      end else if (ce_i) begin
         r <= n;
      end
   end

   assign rmp.level = r.level;
   assign rmp.done  = (r.level == rmp.target);
endmodule // bltf_ramp
`default_nettype wire

// file: rtl/bltf_top.sv
// Backlight sink grouping, dim/off timeouts and fade control
`timescale 1ns/100ps
`default_nettype none
module bltf_top
   import bltf_pkg::*;
#(
   parameter int CLK_KHZ = BLTF_CLK_KHZ
)(
   // Clock, enable and reset
   input  wire logic       mclk_i,
   input  wire logic       rstn_i,
   input  wire logic       ce_i,
   // Register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // Backlight control
   input  wire logic       backlight_group_enable_i,
   input  wire logic [6:0] max_level_i,
   input  wire logic [6:0] dim_level_i,
   input  wire logic [1:0] law_i,
   input  wire logic [6:0] led_indep_on_i,
   // Sink and level outputs
   output logic      [6:0] led_sink_on_o,
   output logic      [6:0] bl_level_o,
   output logic      [2:0] bl_state_o
);
   localparam logic [31:0] TICK_CYC = 32'(BLTF_SEC_MS * CLK_KHZ);

   typedef enum logic [2:0] {
      ST_OFF, ST_FADE_IN, ST_MAX, ST_FADE_DIM, ST_DIM, ST_FADE_OFF
   } bltf_state_t;

   typedef struct packed {
      bltf_state_t st;
      logic        en_q;
      logic [6:0]  secs;
      logic [31:0] tick;
      logic [6:0]  sink_group_select_reg;
      logic [6:0]  off_timeout_seconds;
      logic [6:0]  dim_timeout_seconds;
      logic [7:0]  fade_rate_reg;
      logic [7:0]  rdata;
      logic [6:0]  led_on;
      logic [6:0]  lvl;
   } bltf_top_st_t;

   bltf_top_st_t r;
   bltf_top_st_t n;
   bltf_ramp_if  rmp ();

   logic        turn_on;
   logic        sec_pulse;
   logic [6:0]  tgt;
   logic [3:0]  fade_out_rate;
   logic [3:0]  fade_in_rate;
   logic        group_on;

   // Times a programmed timeout; true on the tick that ends it
   function automatic logic tmo_hit(input logic [6:0] secs,
                                    input logic [6:0] lim,
                                    input logic       pulse);
      tmo_hit = pulse && (lim != 7'h00) && (secs + 7'h01 == lim);
   endfunction

   // Rate fields
   assign fade_out_rate = r.fade_rate_reg[BLTF_FO_MSB:BLTF_FO_LSB];
   assign fade_in_rate  = r.fade_rate_reg[BLTF_FI_MSB:BLTF_FI_LSB];

   // Ramp target from the sequencer state
   always_comb begin
      case (r.st)
         ST_FADE_IN, ST_MAX: tgt = max_level_i;
         ST_FADE_DIM, ST_DIM: tgt = dim_level_i;
         default: tgt = 7'h00;
      endcase
   end

   // Ramp control: up uses fade-in rate, down uses fade-out rate
   assign rmp.target   = tgt;
   assign rmp.law      = law_i;
   assign rmp.step_cyc = (tgt > rmp.level)
                       ? bltf_step_cyc(fade_in_rate, CLK_KHZ)
                       : bltf_step_cyc(fade_out_rate, CLK_KHZ);

   // Sequencer, timeouts and registers
   always_comb begin
      n = r;
      turn_on = backlight_group_enable_i && !r.en_q;
      n.en_q = backlight_group_enable_i;
      // One-second tick
      sec_pulse = (r.tick + 32'h0000_0001 >= TICK_CYC);
      n.tick = sec_pulse ? 32'h0000_0000 : r.tick + 32'h0000_0001;
      if (sec_pulse) begin
         n.secs = r.secs + 7'h01;
      end
      // Register writes; reserved bit 7 is not stored, except at the fade offset, which keeps all 8 bits
      if (reg_wr_i) begin
         case (reg_addr_i)
            BLTF_OFS_SINK_SEL: n.sink_group_select_reg = reg_wdata_i[6:0];
            BLTF_OFS_OFF_TMO: n.off_timeout_seconds = reg_wdata_i[6:0];
            BLTF_OFS_DIM_TMO: n.dim_timeout_seconds = reg_wdata_i[6:0];
            BLTF_OFS_FADE: n.fade_rate_reg = reg_wdata_i;
            default: ;
         endcase
      end
      // Register reads, unmapped offsets return zero
      if (reg_rd_i) begin
         case (reg_addr_i)
            BLTF_OFS_SINK_SEL: n.rdata = {1'b0, r.sink_group_select_reg};
            BLTF_OFS_OFF_TMO: n.rdata = {1'b0, r.off_timeout_seconds};
            BLTF_OFS_DIM_TMO: n.rdata = {1'b0, r.dim_timeout_seconds};
            BLTF_OFS_FADE: n.rdata = r.fade_rate_reg;
            default: n.rdata = 8'h00;
         endcase
      end
      // State machine
      case (r.st)
         ST_OFF: begin
            if (turn_on) begin
               n.st = ST_FADE_IN;
            end
         end
         ST_FADE_IN: begin
            if (!backlight_group_enable_i) begin
               n.st = ST_FADE_OFF;
            end else if (rmp.done) begin
               n.st = ST_MAX;
               n.secs = 7'h00;
               n.tick = 32'h0000_0000;
            end
         end
         ST_MAX: begin
            if (!backlight_group_enable_i) begin
               n.st = ST_FADE_OFF;
            end else if (r.dim_timeout_seconds != 7'h00) begin
               if (tmo_hit(r.secs, r.dim_timeout_seconds, sec_pulse)) begin
                  n.st = ST_FADE_DIM;
               end
            end else if (tmo_hit(r.secs, r.off_timeout_seconds,
                                 sec_pulse)) begin
               n.st = ST_FADE_OFF;
            end
         end
         ST_FADE_DIM: begin
            if (!backlight_group_enable_i) begin
               n.st = ST_FADE_OFF;
            end else if (rmp.done) begin
               n.st = ST_DIM;
               n.secs = 7'h00;
               n.tick = 32'h0000_0000;
            end
         end
         ST_DIM: begin
            if (!backlight_group_enable_i) begin
               n.st = ST_FADE_OFF;
            end else if (tmo_hit(r.secs, r.off_timeout_seconds,
                                 sec_pulse)) begin
               n.st = ST_FADE_OFF;
            end
         end
         ST_FADE_OFF: begin
            if (turn_on) begin
               n.st = ST_FADE_IN;
            end else if (rmp.done) begin
               n.st = ST_OFF;
            end
         end
         default: n.st = ST_OFF;
      endcase
      // Sinks: independent ones follow their own drive, others the group
      group_on = (rmp.level != 7'h00);
      for (int i = 0; i < BLTF_NUM_LEDS; i++) begin
         n.led_on[i] = r.sink_group_select_reg[i]
                     ? led_indep_on_i[i]
                     : group_on;
      end
      n.lvl = rmp.level;
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r <= '0;
         r.st <= ST_OFF;
         r.sink_group_select_reg <= BLTF_RST_SINK_SEL;
         r.off_timeout_seconds <= BLTF_RST_OFF_TMO;
         r.dim_timeout_seconds <= BLTF_RST_DIM_TMO;
         r.fade_rate_reg <= BLTF_RST_FADE;
      end else if (ce_i) begin
         r <= n;
      end
   end

   // Fade ramp engine
   bltf_ramp u_ramp (
      .mclk_i (mclk_i),
      .rstn_i (rstn_i),
      .ce_i   (ce_i),
      .rmp    (rmp.eng)
   );

   // Outputs straight from flip-flops
   assign reg_rdata_o   = r.rdata;
   assign led_sink_on_o = r.led_on;
   assign bl_level_o    = r.lvl;
   assign bl_state_o    = r.st;
endmodule // bltf_top
`default_nettype wire

// file: dv/bltf_top_assertions.sv
// Port assertions for backlight sink, state level and fade control
`timescale 1ns/100ps
`default_nettype none
module bltf_chk
   import bltf_pkg::*;
#(
   parameter int CLK_KHZ = BLTF_CLK_KHZ
)(
   // Clock, reset and register writes
   input wire logic       mclk_i,
   input wire logic       rstn_i,
   input wire logic       ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   // Backlight inputs and outputs
   input wire logic       backlight_group_enable_i,
   input wire logic [6:0] max_level_i,
   input wire logic [6:0] dim_level_i,
   input wire logic [6:0] led_indep_on_i,
   input wire logic [6:0] led_sink_on_o,
   input wire logic [6:0] bl_level_o,
   input wire logic [2:0] bl_state_o
);
   logic [6:0] sel_r;
   logic [6:0] sel_q;
   logic [6:0] ind_q;
   // Shadow of sink select, delayed to line up with the sink outputs
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sel_r <= 7'h00;
         sel_q <= 7'h00;
         ind_q <= 7'h00;
      end else if (ce_i) begin
         if (reg_wr_i && reg_addr_i == BLTF_OFS_SINK_SEL) begin
            sel_r <= reg_wdata_i[6:0];
         end
         sel_q <= sel_r;
         ind_q <= led_indep_on_i;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i || !ce_i);
   indep_sink_a: assert property (
      (led_sink_on_o & sel_q) == (ind_q & sel_q))
      else $error("independent sink differs from its request");
   group_sink_a: assert property (
      (led_sink_on_o & ~sel_q) == ({7{bl_level_o != 7'h00}} & ~sel_q))
      else $error("grouped sink does not follow backlight");
   off_dark_a: assert property (
      bl_state_o == 3'd0 |-> bl_level_o == 7'h00)
      else $error("backlight lit while off");
   dim_hold_a: assert property (
      bl_state_o == 3'd4 |-> bl_level_o == dim_level_i)
      else $error("dim state not at dim level");
   max_hold_a: assert property (
      bl_state_o == 3'd2 |-> bl_level_o == max_level_i)
      else $error("max state not at max level");
   one_step_a: assert property (
      $changed(bl_level_o) |->
      7'(bl_level_o - $past(bl_level_o)) inside {7'h01, 7'h7f})
      else $error("level jumped more than one code");
   fade_up_a: assert property (
      bl_state_o == 3'd1 && $past(bl_state_o) == 3'd1
      |-> bl_level_o >= $past(bl_level_o))
      else $error("level fell during fade in");
   fade_down_a: assert property (
      bl_state_o == 3'd5 && $past(bl_state_o) == 3'd5
      |-> bl_level_o <= $past(bl_level_o))
      else $error("level rose during fade out");
   turn_on_a: assert property (
      $rose(backlight_group_enable_i) && bl_state_o == 3'd0
      |-> ##[1:3] bl_state_o == 3'd1)
      else $error("switch on did not start fade in");
   // Main scenarios reached
   cover property (bl_state_o == 3'd4);
   cover property (bl_state_o == 3'd5);
   cover property ($rose(backlight_group_enable_i));
endmodule // bltf_chk
bind bltf_top bltf_chk #(.CLK_KHZ(CLK_KHZ)) i_bltf_chk (
   .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i),
   .backlight_group_enable_i(backlight_group_enable_i),
   .max_level_i(max_level_i), .dim_level_i(dim_level_i),
   .led_indep_on_i(led_indep_on_i), .led_sink_on_o(led_sink_on_o),
   .bl_level_o(bl_level_o), .bl_state_o(bl_state_o));
`default_nettype wire

// file: dv/bltf_host.sv
// Host model driving the register strobe port
`timescale 1ns/100ps
`default_nettype none
module bltf_host (
   // Clock and read data
   input  wire logic       mclk_i,
   input  wire logic [7:0] reg_rdata_i,
   // Strobe port
   output logic      [7:0] reg_addr_o,
   output logic      [7:0] reg_wdata_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o
);
   // Idle bus at time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   // One-cycle write; released lines show no stale value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1;
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(posedge mclk_i);
      #1;
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask
   // One-cycle read, data taken once the strobe edge has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      #1;
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(posedge mclk_i);
      #1;
      d = reg_rdata_i;
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
   endtask
endmodule // bltf_host
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for backlight sink, timeout and fade control
`timescale 1ns/100ps
`default_nettype none
module tb;
   import bltf_pkg::*;
   logic             mclk   = 1'b0;
   logic             rstn   = 1'b0;
   logic             ce     = 1'b1;
   logic             en     = 1'b0;
   logic [6:0]       max_lv = 7'h03;
   logic [6:0]       dim_lv = 7'h01;
   logic [1:0]       law    = 2'h1;
   logic [6:0]       ind    = 7'h7f;
   wire  logic [7:0] addr, wdata, rdata;
   wire  logic       wr, rd;
   wire  logic [6:0] sink, lvl;
   wire  logic [2:0] st;
   int               miscompares = 0;
   int               checked = 0;
   int               cyc = 0;
   bltf_top #(.CLK_KHZ(1)) i_bltf_top (
      .mclk_i(mclk), .rstn_i(rstn), .ce_i(ce), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .backlight_group_enable_i(en),
      .max_level_i(max_lv), .dim_level_i(dim_lv), .law_i(law),
      .led_indep_on_i(ind), .led_sink_on_o(sink), .bl_level_o(lvl),
      .bl_state_o(st));
   bltf_host i_bltf_host (
      .mclk_i(mclk), .reg_rdata_i(rdata), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
   // Clock at 25 MHz
   always #20 mclk = ~mclk;
   // Cycle ceiling against a hung wait
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int n, input int lo, input int hi);
      checked++;
      if (n < lo || n > hi) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h..%h", $time, n, lo, hi);
      end
   endtask
   task automatic give_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic set_en(input logic v);
      @(posedge mclk);
      #1;
      en = v;
   endtask
   // Cycles until the sequencer shows a state, bounded
   task automatic wait_st(input logic [2:0] s, output int n);
      n = 0;
      while (st !== s && n < 3000) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask
   // Full-scale fade time in ms for rate codes 0 to b and f
   function automatic int fade_ms(input logic [3:0] c);
      case (c)
         4'h0: return 100;
         4'hb: return 3500;
         4'hf: return 5500;
         default: return 300 * int'(c);
      endcase
   endfunction
   task automatic t_regs();
      logic [7:0] d;
      for (int a = 5; a <= 9; a++) begin
         i_bltf_host.rd(8'(a), d);
         chk_val(d, 8'h00);
         i_bltf_host.wr(8'(a), 8'hff);
         i_bltf_host.rd(8'(a), d);
         chk_val(d, a == 9 ? 8'h00 : a == 8 ? 8'hff : 8'h7f);
      end
      $display("test regs done");
   endtask
   task automatic t_tmo();
      int n;
      ind = 7'h41;
      i_bltf_host.wr(BLTF_OFS_SINK_SEL, 8'h55);
      i_bltf_host.wr(BLTF_OFS_OFF_TMO, 8'h01);
      i_bltf_host.wr(BLTF_OFS_DIM_TMO, 8'h01);
      i_bltf_host.wr(BLTF_OFS_FADE, 8'h00);
      set_en(1'b1);
      wait_st(3'd2, n);
      chk_rng(n, 1, 8);
      chk_val({1'b0, sink}, 8'h6b);
      wait_st(3'd4, n);
      chk_rng(n, 995, 1010);
      chk_val({1'b0, lvl}, 8'h01);
      wait_st(3'd0, n);
      chk_rng(n, 995, 1010);
      chk_val({1'b0, sink}, 8'h41);
      set_en(1'b0);
      $display("test timeouts done");
   endtask
   task automatic t_fade();
      logic [3:0] codes [4] = '{4'h0, 4'h1, 4'hb, 4'hf};
      int n;
      int e;
      logic [7:0] d;
      max_lv = 7'h08;
      law = 2'h0;
      i_bltf_host.wr(BLTF_OFS_DIM_TMO, 8'h00);
      i_bltf_host.wr(BLTF_OFS_OFF_TMO, 8'h00);
      foreach (codes[i]) begin
         e = 8 * (fade_ms(codes[i]) > 126 ? fade_ms(codes[i]) / 127 : 1);
         i_bltf_host.wr(BLTF_OFS_FADE, {codes[i], codes[i]});
         set_en(1'b1);
         wait_st(3'd1, n);
         wait_st(3'd2, n);
         chk_rng(n, e - 3, e + 3);
         chk_val({1'b0, lvl}, 8'h08);
         if (i == 0) begin
            repeat (1100) @(posedge mclk);
            #1;
            chk_val({5'h00, st}, 8'h02);
            // Clock enable low: enable drop and write are both ignored
            ce = 1'b0;
            en = 1'b0;
            i_bltf_host.wr(BLTF_OFS_FADE, 8'h33);
            chk_val({5'h00, st}, 8'h02);
            en = 1'b1;
            ce = 1'b1;
            i_bltf_host.rd(BLTF_OFS_FADE, d);
            chk_val(d, 8'h00);
         end
         set_en(1'b0);
         wait_st(3'd5, n);
         wait_st(3'd0, n);
         chk_rng(n, e - 3, e + 3);
      end
      $display("test fades done");
   endtask
   // Cubic laws stretch every step below their low band
   task automatic t_law();
      int n;
      int m;
      i_bltf_host.wr(BLTF_OFS_FADE, 8'h00);
      for (int k = 2; k <= 3; k++) begin
         m = (k == 2) ? 2 : 4;
         law = 2'(k);
         set_en(1'b1);
         wait_st(3'd1, n);
         wait_st(3'd2, n);
         chk_rng(n, 8 * m - 3, 8 * m + 3);
         set_en(1'b0);
         wait_st(3'd0, n);
         chk_rng(n, 8 * m - 3, 8 * m + 3);
      end
      $display("test laws done");
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge mclk);
      #1;
      rstn = 1'b1;
      t_regs();
      t_tmo();
      t_fade();
      t_law();
      give_verdict();
   end
endmodule // tb
`default_nettype wire
